/* File: design/gpio_cd_map.svh */
// How it works
// R1 - Select bit 1 routes the peripheral signal to the pin, 0 gives port
// R2 - Direction bit 1 makes the pin an output, 0 an input
// R3 - Reset clears every function-select bit, so all pins start as port pins
// R4 - Reset clears every direction bit; data latches reset to zero
// R5 - Output pin drives its data latch; data read returns the latch
// R6 - Input pin is not driven; data read returns the sampled pin level
// R7 - Direction and function select are independent for every single bit
// R8 - Port C select bits 7..5 give pulse group A, bits 4..2 group B
// R9 - Port C bit 1 serial0 clock, bit 0 serial0 out; bits 3,2 feed selects
// R10 - Port D bits 5,2 serial1/2 clocks; bits 4,1 serial1/2 data outputs
// R11 - Software keeps port D select bits 7, 6, 3 and 0 at zero
`ifndef GPIO_CD_MAP_SVH
`define GPIO_CD_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_D_DATA 6'h16
`define IDX_C_DATA 6'h17
`define IDX_D_DIR 6'h1E
`define IDX_C_DIR 6'h1F
`define IDX_C_FSEL 6'h27
`define IDX_D_FSEL 6'h28

`define REG_RESET 8'h00
`define LATCH_RESET 8'h00
// Port D select bits that may be set
`define D_FSEL_MASK 8'h36
// Peripheral drive enables on port C bits 7..2
`define C_FIXED_OE 6'h3F
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: design/gpio_cd_pkg.sv */
package gpio_cd_pkg;

    // Drive of one eight-bit port towards its pads
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pinDrive_s;

endpackage

/* File: design/gpio_cd.sv */
`timescale 1ns/1ps
`include "gpio_cd_map.svh"

module gpio_cd
    import gpio_cd_pkg::*;
(
    input wire logic clk, // 50 MHz system clock
    input wire logic arst_n, // Asynchronous reset
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [7:0] cPinIn, // Port C pad levels
    output pinDrive_s cPin, // Port C pad drive
    input wire logic [7:0] dPinIn, // Port D pad levels
    output pinDrive_s dPin, // Port D pad drive
    input wire logic [2:0] pulseA, // Pulse group A outputs
    input wire logic [2:0] pulseB, // Pulse group B outputs
    input wire logic sclk0Out, // Serial 0 clock out
    input wire logic sclk0Oe, // Serial 0 clock drive
    input wire logic sdo0, // Serial 0 data out
    input wire logic sclk1Out, // Serial 1 clock out
    input wire logic sclk1Oe, // Serial 1 clock drive
    input wire logic sdo1, // Serial 1 data out
    input wire logic sclk2Out, // Serial 2 clock out
    input wire logic sclk2Oe, // Serial 2 clock drive
    input wire logic sdo2, // Serial 2 data out
    output logic sclk0In, // Serial 0 clock from pad
    output logic sclk1In, // Serial 1 clock from pad
    output logic sclk2In, // Serial 2 clock from pad
    output logic serial0_data_in, // Serial 0 data in
    output logic serial1_data_in, // Serial 1 data in
    output logic serial2_data_in, // Serial 2 data in
    output logic serial0_select_in, // Serial 0 select in
    output logic serial1_select_in, // Serial 1 select in
    output logic serial2_select_in, // Serial 2 select in
    output logic ext_irq_line_2 // External interrupt line
);

    // ==========================================================
    // Reset release
    logic [1:0] rstPipe;
    logic rstN;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstN = rstPipe[1];

    // ==========================================================
    // Pad input synchronisers
    // A high level counts once the second and third stages agree; a low one as soon as they differ
    function automatic logic [7:0] settle(input logic [7:0] s2,
        input logic [7:0] s3, input logic [7:0] level);
        settle = (s2 & s3) | (level & ~(s2 ^ s3));
    endfunction

    logic [7:0] cS1, cS2, cS3, cLevel;
    logic [7:0] dS1, dS2, dS3, dLevel;
    logic [7:0] next_cLevel, next_dLevel;

    assign next_cLevel = settle(cS2, cS3, cLevel);
    assign next_dLevel = settle(dS2, dS3, dLevel);

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cS1 <= 8'h00;
            cS2 <= 8'h00;
            cS3 <= 8'h00;
            cLevel <= 8'h00;
            dS1 <= 8'h00;
            dS2 <= 8'h00;
            dS3 <= 8'h00;
            dLevel <= 8'h00;
        end else begin
            cS1 <= cPinIn;
            cS2 <= cS1;
            cS3 <= cS2;
            cLevel <= next_cLevel;
            dS1 <= dPinIn;
            dS2 <= dS1;
            dS3 <= dS2;
            dLevel <= next_dLevel;
        end
    end

    // ==========================================================
    // Bus write side
    logic awHeld, wHeld;
    logic [5:0] awIdx;
    logic [7:0] wByte;
    logic wLane;
    logic doWrite, wHit;

    assign s_axi_awready = !awHeld;
    assign s_axi_wready = !wHeld;
    assign doWrite = awHeld && wHeld && !s_axi_bvalid;
    assign wHit = (awIdx == `IDX_D_DATA) || (awIdx == `IDX_C_DATA) ||
        (awIdx == `IDX_D_DIR) || (awIdx == `IDX_C_DIR) ||
        (awIdx == `IDX_C_FSEL) || (awIdx == `IDX_D_FSEL);

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awIdx <= 6'h00;
            wByte <= 8'h00;
            wLane <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !awHeld) begin
                awHeld <= 1'b1;
                awIdx <= s_axi_awaddr[7:2];
            end else if (doWrite) begin
                awHeld <= 1'b0;
            end
            if (s_axi_wvalid && !wHeld) begin
                wHeld <= 1'b1;
                wByte <= s_axi_wdata[7:0];
                wLane <= s_axi_wstrb[0];
            end else if (doWrite) begin
                wHeld <= 1'b0;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wHit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Port registers
    logic [7:0] latchC, latchD, dirC, dirD, fselC, fselD;
    logic wEn;

    assign wEn = doWrite && wLane;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            latchC <= `LATCH_RESET;
            latchD <= `LATCH_RESET;
            dirC <= `REG_RESET; // R4
            dirD <= `REG_RESET; // R4
            fselC <= `REG_RESET; // R3
            fselD <= `REG_RESET; // R3
        end else if (wEn) begin
            case (awIdx)
                `IDX_C_DATA: latchC <= wByte;
                `IDX_D_DATA: latchD <= wByte;
                `IDX_C_DIR: dirC <= wByte; // R7
                `IDX_D_DIR: dirD <= wByte; // R7
                `IDX_C_FSEL: fselC <= wByte; // R7
                `IDX_D_FSEL: fselD <= wByte & `D_FSEL_MASK; // R11
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Bus read side
    logic [7:0] rdByte;
    logic rHit;
    logic [5:0] arIdx;

    assign arIdx = s_axi_araddr[7:2];
    assign s_axi_arready = !s_axi_rvalid;
    assign rHit = (arIdx == `IDX_D_DATA) || (arIdx == `IDX_C_DATA) ||
        (arIdx == `IDX_D_DIR) || (arIdx == `IDX_C_DIR) ||
        (arIdx == `IDX_C_FSEL) || (arIdx == `IDX_D_FSEL);
    // Write-only registers read as zero
    assign rdByte = (arIdx == `IDX_C_DATA) ?
        ((dirC & latchC) | (~dirC & cLevel)) : // R5 R6
        (arIdx == `IDX_D_DATA) ?
        ((dirD & latchD) | (~dirD & dLevel)) : 8'h00; // R5 R6

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rdByte};
            s_axi_rresp <= rHit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Pin multiplexing
    logic [7:0] cFunc, cFuncOe, dFunc, dFuncOe;
    pinDrive_s next_cPin, next_dPin;

    assign cFunc = {pulseA[0], pulseA[1], pulseA[2], pulseB[0],
        pulseB[1], pulseB[2], sclk0Out, sdo0}; // R8 R9
    assign cFuncOe = {`C_FIXED_OE, 2'b00} | {6'h00, sclk0Oe, 1'b1}; // R9
    assign dFunc = {2'b00, sclk1Out, sdo1, 1'b0, sclk2Out, sdo2,
        1'b0}; // R10
    assign dFuncOe = {2'b00, sclk1Oe, 1'b1, 1'b0, sclk2Oe, 1'b1,
        1'b0}; // R10
    assign next_cPin.out = (fselC & cFunc) | (~fselC & latchC); // R1 R5
    assign next_cPin.oe = (fselC & cFuncOe) | (~fselC & dirC); // R1 R2 R6
    assign next_dPin.out = (fselD & dFunc) | (~fselD & latchD); // R1 R5
    assign next_dPin.oe = (fselD & dFuncOe) | (~fselD & dirD); // R1 R2 R6

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cPin <= '0;
            dPin <= '0;
        end else begin
            cPin <= next_cPin;
            dPin <= next_dPin;
        end
    end

    // ==========================================================
    // Peripheral inputs
    assign sclk0In = cLevel[1];
    assign sclk1In = dLevel[5];
    assign sclk2In = dLevel[2];
    assign serial0_data_in = dLevel[7];
    assign serial0_select_in = dLevel[6];
    assign serial1_data_in = dLevel[3];
    assign ext_irq_line_2 = dLevel[3];
    assign serial2_data_in = dLevel[0];
    // Selects idle high while the pin carries a pulse output
    assign serial2_select_in = fselC[3] | cLevel[3]; // R9
    assign serial1_select_in = fselC[2] | cLevel[2]; // R9

    // ==========================================================
    // Checks
    sequence s_c3High;
        cPinIn[3] [*3];
    endsequence

    property p_routeC7;
        @(posedge clk) disable iff (!rstN)
        fselC[7] |=> cPin.out[7] == $past(pulseA[0]) && cPin.oe[7];
    endproperty
    a_routeC7: assert property (p_routeC7) // R8
        else $error("pulse A0 not on port C pin 7");

    property p_portOut;
        @(posedge clk) disable iff (!rstN)
        (!fselC[0] && dirC[0]) |=>
            cPin.out[0] == $past(latchC[0]) && cPin.oe[0];
    endproperty
    a_portOut: assert property (p_portOut) // R5
        else $error("port C pin 0 output does not follow latch");

    property p_portIn;
        @(posedge clk) disable iff (!rstN)
        (!fselD[7] && !dirD[7]) |=> !dPin.oe[7];
    endproperty
    a_portIn: assert property (p_portIn) // R6
        else $error("input pin D7 is driven");

    property p_resetState;
        @(posedge clk)
        $rose(rstN) |-> (fselC | fselD | dirC | dirD) == 8'h00;
    endproperty
    a_resetState: assert property (p_resetState) // R3
        else $error("select or direction not clear after reset");

    property p_sclk0;
        @(posedge clk) disable iff (!rstN)
        fselC[1] |=> cPin.oe[1] == $past(sclk0Oe) &&
            cPin.out[1] == $past(sclk0Out);
    endproperty
    a_sclk0: assert property (p_sclk0) // R9
        else $error("serial 0 clock not on port C pin 1");

    property p_sel2;
        @(posedge clk) disable iff (!rstN)
        s_c3High ##2 !fselC[3] |-> serial2_select_in;
    endproperty
    a_sel2: assert property (p_sel2) // R9
        else $error("serial 2 select does not follow pin C3");

    property p_sclk1;
        @(posedge clk) disable iff (!rstN)
        fselD[5] |=> dPin.oe[5] == $past(sclk1Oe) &&
            dPin.out[5] == $past(sclk1Out);
    endproperty
    a_sclk1: assert property (p_sclk1) // R10
        else $error("serial 1 clock not on port D pin 5");

    property p_sdo2;
        @(posedge clk) disable iff (!rstN)
        fselD[1] |=> dPin.out[1] == $past(sdo2) && dPin.oe[1];
    endproperty
    a_sdo2: assert property (p_sdo2) // R10
        else $error("serial 2 data not on port D pin 1");

    property p_indep;
        @(posedge clk) disable iff (!rstN)
        (fselC[2] && !fselC[3] && dirC[3]) |=>
            cPin.out[3] == $past(latchC[3]) &&
            cPin.out[2] == $past(pulseB[2]);
    endproperty
    a_indep: assert property (p_indep) // R7
        else $error("neighbouring pins not independent");

    property p_readLatch;
        @(posedge clk) disable iff (!rstN)
        (s_axi_arvalid && s_axi_arready && arIdx == `IDX_C_DATA) |=>
            s_axi_rvalid && (s_axi_rdata[7:0] & $past(dirC)) ==
            ($past(latchC) & $past(dirC));
    endproperty
    a_readLatch: assert property (p_readLatch) // R5
        else $error("data read of outputs does not return latch");

    property p_dirReg;
        @(posedge clk) disable iff (!rstN)
        (wEn && awIdx == `IDX_D_DIR) |=> ##1 dPin.oe[0] ==
            ($past(wByte[0], 2) & ~fselD[0]);
    endproperty
    a_dirReg: assert property (p_dirReg) // R2
        else $error("direction write does not steer pin D0");

endmodule

/* File: tb/pad_model.sv */
`timescale 1ns/1ps
module pad_model
    import gpio_cd_pkg::*;
(
    input wire logic clk, // System clock
    input pinDrive_s drv, // Design drive of the port
    input wire logic [7:0] extVal, // Board level
    input wire logic [7:0] extOe, // Board drives the pad
    output logic [7:0] level // Resolved pad level
);
    logic [7:0] flt = 8'h5A;
    // Undriven pads wander so a stale level never looks like data
    always @(posedge clk) begin
        flt <= ~level;
    end
    assign level = (drv.oe & drv.out) | (~drv.oe & extOe & extVal)
        | (~drv.oe & ~extOe & flt);
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`include "gpio_cd_map.svh"
module tb_top
    import gpio_cd_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] cPinIn, dPinIn, extC = 8'h00, extD = 8'h00;
    pinDrive_s cPin, dPin;
    logic [2:0] pulseA = 3'h0, pulseB = 3'h0;
    logic sclk0Out = 1'b0, sclk0Oe = 1'b0, sdo0 = 1'b0;
    logic sclk1Out = 1'b0, sclk1Oe = 1'b0, sdo1 = 1'b0;
    logic sclk2Out = 1'b0, sclk2Oe = 1'b0, sdo2 = 1'b0;
    logic sclk0In, sclk1In, sclk2In, ext_irq_line_2;
    logic serial0_data_in, serial1_data_in, serial2_data_in;
    logic serial0_select_in, serial1_select_in, serial2_select_in;
    int err_total = 0, checks_done = 0, cyc = 0;
    integer seed = 32'h56561398;
    int dirC, dirD, fsC, fsD, latC, latD, oeC, outC, oeD, outD, lvC, lvD;

    gpio_cd u_dut (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cPinIn, .cPin,
        .dPinIn, .dPin, .pulseA, .pulseB, .sclk0Out, .sclk0Oe, .sdo0,
        .sclk1Out, .sclk1Oe, .sdo1, .sclk2Out, .sclk2Oe, .sdo2, .sclk0In,
        .sclk1In, .sclk2In, .serial0_data_in, .serial1_data_in,
        .serial2_data_in, .serial0_select_in, .serial1_select_in,
        .serial2_select_in, .ext_irq_line_2);
    pad_model u_padC (.clk, .drv(cPin), .extVal(extC), .extOe(8'hFF),
        .level(cPinIn));
    pad_model u_padD (.clk, .drv(dPin), .extVal(extD), .extOe(8'hFF),
        .level(dPinIn));

    // ==================================================
    // Clock, timeout and report
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask

    // ==================================================
    // Register bus master
    task automatic axWr(logic [7:0] a, logic [7:0] d, output logic [1:0] r);
        logic aD, wD;
        aD = 1'b0;
        wD = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aD && wD)) begin
            @(posedge clk);
            if (s_axi_awready) aD = 1'b1;
            if (s_axi_wready) wD = 1'b1;
            s_axi_awvalid <= !aD;
            s_axi_wvalid <= !wD;
        end
        do @(posedge clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axRd(logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic cfg(logic [5:0] idx, int v);
        logic [1:0] r;
        axWr({idx, 2'b00}, v[7:0], r);
        chk("write response", {30'h0, `RESP_OKAY}, {30'h0, r});
    endtask

    // ==================================================
    // Reference model and comparison
    task automatic verify();
        int pc, pcOe, pd, pdOe;
        logic [31:0] d;
        logic [1:0] r;
        pc = {pulseA[0], pulseA[1], pulseA[2], pulseB[0], pulseB[1],
            pulseB[2], sclk0Out, sdo0};
        pcOe = {6'h3F, sclk0Oe, 1'b1};
        pd = {2'h0, sclk1Out, sdo1, 1'b0, sclk2Out, sdo2, 1'b0};
        pdOe = {2'h0, sclk1Oe, 2'h2, sclk2Oe, 2'h2};
        oeC = ((fsC & pcOe) | (~fsC & dirC)) & 32'hFF;
        outC = ((fsC & pc) | (~fsC & latC)) & oeC;
        oeD = ((fsD & pdOe) | (~fsD & dirD)) & 32'hFF;
        outD = ((fsD & pd) | (~fsD & latD)) & oeD;
        lvC = (outC | (~oeC & extC)) & 32'hFF;
        lvD = (outD | (~oeD & extD)) & 32'hFF;
        chk("port c pads", {oeC[7:0], outC[7:0]},
            {cPin.oe, cPin.out & cPin.oe});
        chk("port d pads", {oeD[7:0], outD[7:0]},
            {dPin.oe, dPin.out & dPin.oe});
        axRd({`IDX_C_DATA, 2'b00}, d, r);
        chk("port c data", ((dirC & latC) | (~dirC & lvC)) & 255, d);
        axRd({`IDX_D_DATA, 2'b00}, d, r);
        chk("port d data", ((dirD & latD) | (~dirD & lvD)) & 255, d);
        chk("serial inputs", {lvC[1], lvD[5], lvD[2], lvD[7], lvD[6],
            lvD[3], lvD[3], lvD[0], fsC[3] | lvC[3], fsC[2] | lvC[2]},
            {sclk0In, sclk1In, sclk2In, serial0_data_in, serial0_select_in,
            serial1_data_in, ext_irq_line_2, serial2_data_in,
            serial2_select_in, serial1_select_in});
    endtask

    // ==================================================
    // Main sequence
    initial begin
        logic [31:0] rv, d;
        logic [1:0] r;
        {dirC, dirD, fsC, fsD, latC, latD} = '0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rv = $random(seed);
        extC <= rv[7:0];
        extD <= rv[15:8];
        repeat (10) @(posedge clk);
        verify();
        axRd({`IDX_C_DIR, 2'b00}, d, r);
        chk("direction read", 32'h0, d);
        chk("direction resp", {30'h0, `RESP_OKAY}, {30'h0, r});
        axRd(8'hFC, d, r);
        chk("unmapped read", 32'h0, d);
        chk("unmapped resp", {30'h0, `RESP_SLVERR}, {30'h0, r});
        axWr(8'h00, 8'hFF, r);
        chk("unmapped write", {30'h0, `RESP_SLVERR}, {30'h0, r});
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            rv = $random(seed);
            extC <= rv[7:0];
            extD <= rv[15:8];
            {pulseA, pulseB} <= rv[21:16];
            {sclk0Out, sclk0Oe, sdo0, sclk1Out, sclk1Oe, sdo1} <= rv[27:22];
            {sclk2Out, sclk2Oe, sdo2} <= rv[30:28];
            latC = $random(seed) & 255;
            latD = $random(seed) & 255;
            dirC = $random(seed) & 255;
            dirD = $random(seed) & 255;
            fsC = $random(seed) & 255;
            fsD = $random(seed) & 32'h36;
            cfg(`IDX_C_DATA, latC);
            cfg(`IDX_D_DATA, latD);
            cfg(`IDX_C_DIR, dirC);
            cfg(`IDX_D_DIR, dirD);
            cfg(`IDX_C_FSEL, fsC);
            cfg(`IDX_D_FSEL, fsD);
            repeat (10) @(posedge clk);
            verify();
        end
        $display("test pin modes done");
        s_axi_wstrb <= 4'h0;
        cfg(`IDX_C_DIR, ~dirC);
        s_axi_wstrb <= 4'hF;
        repeat (10) @(posedge clk);
        verify();
        $display("test masked write done");
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        {dirC, dirD, fsC, fsD, latC, latD} = '0;
        repeat (12) @(posedge clk);
        verify();
        $display("test second reset done");
        test_done();
    end
endmodule
